// ==== adcs_clkdiv.sv ====
// divider producing internal clock enable pulses and mid-cycle pulses
`default_nettype none
module adcs_clkdiv #(
   parameter int unsigned DIV = adcs_pkg::DIV_RATIO
) (
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   output var  logic tick_o,
   output var  logic half_o
);
   import adcs_pkg::*;
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   localparam logic [W-1:0] MID  = W'(DIV / 2 - 1);

   logic [W-1:0] cnt_q;

   // free-running phase counter of the input clock
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   // tick starts an internal cycle, half marks its middle
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_o <= 1'b0;
         half_o <= 1'b0;
      end else begin
         tick_o <= (cnt_q == LAST);
         half_o <= (cnt_q == MID);
      end
   end

   a_div_period : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      tick_o |=> !tick_o [*3] ##1 tick_o)
      else $error("internal clock tick is not one in four input clocks");
endmodule
`default_nettype wire

// ==== adcs_host_model.sv ====
// host-side bus agent that strobes conversions and reads result bytes
`default_nettype none
module adcs_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic [7:0] result_bus_i,
   input  wire logic       result_bus_oe_i,
   output var  logic       chip_sel_o,
   output var  logic       chip_en_n_o,
   output var  logic       wr_n_o,
   output var  logic       rd_n_o,
   output var  logic       byte_low_sel_o,
   output var  logic       sign_or_range_select_o
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   // idle bus: selected, strobes high; every task is entered at a falling edge
   initial begin
      chip_sel_o = 1'b1;
      chip_en_n_o = 1'b0;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      byte_low_sel_o = 1'b0;
      sign_or_range_select_o = 1'b0;
   end

   // selects are left to the caller so unselected strobes can be tried
   task automatic set_sel(input logic cs, input logic ce_n);
      chip_sel_o = cs;
      chip_en_n_o = ce_n;
   endtask

   // held keeps the line low, to show that a level does not retrigger
   task automatic strobe_write(input logic held);
      wr_n_o = 1'b0;
      @(negedge sys_clk_i);
      wr_n_o = ~held;
   endtask

   task automatic release_write();
      wr_n_o = 1'b1;
      @(negedge sys_clk_i);
   endtask

   // the port is registered, so the byte is taken two edges into the cycle
   task automatic read_byte(input logic lo, input logic rs, output logic [7:0] d, output logic oe);
      byte_low_sel_o = lo;
      sign_or_range_select_o = rs;
      rd_n_o = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      d = result_bus_i;
      oe = result_bus_oe_i;
      rd_n_o = 1'b1;  // rising edge steps the free-run byte counter
      repeat (2) @(negedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// ==== adcs_pkg.sv ====
// constants and types shared by the converter sequencer and its divider
`default_nettype none
package adcs_pkg;
   // internal clock is the input clock divided by this ratio
   localparam int unsigned DIV_RATIO  = 32'h0000_0004;
   localparam int unsigned CNT_W      = 32'h0000_000B;
   // conversion timing, in internal clock cycles
   localparam logic [10:0] CONV_LEN   = 11'h500;  // 1280 cycles per conversion
   localparam logic [10:0] INTEG_LEN  = 11'h100;  // 256 integrate cycles
   localparam logic [10:0] BUSY_FALL  = 11'h483;  // 1155 cycles after start
   localparam logic [10:0] BUSY_LEN   = 11'h344;  // 836 cycles high
   localparam logic [10:0] IGNORE_LEN = 11'h44C;  // 1100 cycles write lockout
   localparam logic [10:0] BUSY_RISE  = BUSY_FALL - BUSY_LEN;
   localparam logic [10:0] INTEG_BEG  = BUSY_RISE - INTEG_LEN;
   localparam logic [10:0] CONV_LAST  = CONV_LEN - 11'h001;
   localparam logic [10:0] TAIL_LEN   = CONV_LEN - BUSY_FALL; // 125 cycles
   // read window after busy falls: 443-1/2 internal cycles, kept in halves
   localparam int unsigned RD_WIN_HALVES = 32'h0000_0377;
   localparam logic [10:0] RD_WIN_SYS =
      11'(RD_WIN_HALVES * DIV_RATIO / 32'h0000_0002);
   // result layout
   localparam int unsigned MAG_W      = 32'h0000_000F;
   localparam int unsigned FLAG_BIT   = 32'h0000_0007;
   // continuous-mode byte order
   localparam logic [1:0]  BYTE_HI_POL  = 2'h0;
   localparam logic [1:0]  BYTE_LO      = 2'h1;
   localparam logic [1:0]  BYTE_HI_OVR  = 2'h2;
   typedef enum logic [0:0] {
      ADCS_IDLE = 1'b0,
      ADCS_RUN  = 1'b1
   } adcs_state_type;
endpackage
`default_nettype wire

// ==== adcs_top.sv ====
// conversion sequencer and three-state result port of an integrating converter
`default_nettype none
module adcs_top (
   input  wire logic                       sys_clk_i,
   input  wire logic                       resetn_i,
   input  wire logic                       free_run_select_i,
   input  wire logic                       chip_sel_i,
   input  wire logic                       chip_en_n_i,
   input  wire logic                       wr_n_i,
   input  wire logic                       rd_n_i,
   input  wire logic                       byte_low_sel_i,
   input  wire logic                       sign_or_range_select_i,
   input  wire logic [adcs_pkg::MAG_W-1:0] mag_i,
   input  wire logic                       positive_i,
   input  wire logic                       overrange_i,
   output var  logic                       busy_o,
   output var  logic                       integrate_o,
   output var  logic                       data_valid_o,
   output var  logic [7:0]                 result_bus_o,
   output var  logic                       result_bus_oe_o
);
   import adcs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // internal clock

   logic tick;
   logic half;

   adcs_clkdiv #(
      .DIV (DIV_RATIO)
   ) u_div (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .tick_o    (tick),
      .half_o    (half)
   );

   ////////////////////////////////////////////////////////////////////////
   // strobe qualification

   logic                 selected;
   logic                 wr_prev_q;
   logic                 rd_prev_q;
   logic                 wr_fall;
   logic                 rd_rise;
   adcs_state_type       state_q;
   adcs_state_type       state_d;
   logic [CNT_W-1:0]     cnt_q;
   logic [CNT_W-1:0]     cnt_d;
   logic                 req_q;
   logic                 req_d;
   logic                 conv_end;

   assign selected = chip_sel_i & ~chip_en_n_i;
   assign wr_fall  = selected & wr_prev_q & ~wr_n_i;
   assign rd_rise  = selected & ~rd_prev_q & rd_n_i;
   assign conv_end = (state_q == ADCS_RUN) & tick & (cnt_q == CONV_LAST);

   // strobe history; pins are already synchronous to the clock
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
      end else begin
         wr_prev_q <= wr_n_i;
         rd_prev_q <= rd_n_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer

   // a start request is honoured when idle or late enough in a conversion;
   // the set wins over the consume so a strobe in that cycle is kept
   always_comb begin
      logic set_req;
      logic take;
      set_req = 1'b0;
      take    = 1'b0;
      state_d = state_q;
      cnt_d   = cnt_q;
      if (!free_run_select_i && wr_fall) begin
         if (state_q == ADCS_IDLE) begin
            set_req = 1'b1;
         end else if (cnt_q >= IGNORE_LEN) begin
            set_req = 1'b1;
         end                                            // else
      end
      case (state_q)
         ADCS_IDLE: begin
            if (tick && (req_q || free_run_select_i)) begin
               state_d = ADCS_RUN;
               cnt_d   = '0;
               take    = 1'b1;
            end
         end
         ADCS_RUN: begin
            if (conv_end) begin
               cnt_d = '0;
               take  = 1'b1;
               if (!(req_q || free_run_select_i)) begin
                  state_d = ADCS_IDLE;
               end
            end else if (tick) begin
               cnt_d = cnt_q + 11'h001;
            end
         end
         default: begin
            state_d = ADCS_IDLE;
            cnt_d   = '0;
         end
      endcase
      req_d = set_req | (req_q & ~take);
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ADCS_IDLE;
         cnt_q   <= '0;
         req_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         req_q   <= req_d;
      end
   end

   // phase outputs decoded from the next count so they stay registered
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_o      <= 1'b0;
         integrate_o <= 1'b0;
      end else begin
         busy_o      <= (state_d == ADCS_RUN) && (cnt_d >= BUSY_RISE)
                        && (cnt_d < BUSY_FALL);
         integrate_o <= (state_d == ADCS_RUN) && (cnt_d >= INTEG_BEG)
                        && (cnt_d < BUSY_RISE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result capture and validity

   logic                 busy_fall;
   logic [MAG_W-1:0]     mag_q;
   logic                 pos_q;
   logic                 ovr_q;

   // busy is decoded from the next count, so its fall is flagged on the last
   // busy tick; capture and valid then land on the same edge as the fall
   assign busy_fall = (state_q == ADCS_RUN) & tick & (cnt_q == BUSY_FALL - 11'h001);

   // the analog side's count is taken as the busy output falls
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mag_q <= '0;
         pos_q <= 1'b0;
         ovr_q <= 1'b0;
      end else if (busy_fall) begin
         mag_q <= mag_i;
         pos_q <= positive_i;
         ovr_q <= overrange_i;
      end
   end

   // valid ends half an internal cycle before busy rises again
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_valid_o <= 1'b0;
      end else if (busy_fall) begin
         data_valid_o <= 1'b1;
      end else if (half && (state_q == ADCS_RUN) && (cnt_q == BUSY_RISE - 11'h001)) begin
         data_valid_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read window and byte sequencing

   logic [CNT_W-1:0]     win_q;
   logic [1:0]           idx_q;
   logic                 win_expire;

   assign win_expire = (win_q == 11'h001);

   // counts input clocks after busy falls; at its expiry the free-run byte counter restarts at the first byte
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         win_q <= '0;
      end else if (busy_fall) begin
         win_q <= RD_WIN_SYS;
      end else if (win_q != '0) begin
         win_q <= win_q - 11'h001;
      end
   end

   // free-run byte counter, stepped by each selected read strobe release
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         idx_q <= BYTE_HI_POL;
      end else if (busy_fall || win_expire) begin
         idx_q <= BYTE_HI_POL;
      end else if (free_run_select_i && rd_rise) begin
         idx_q <= (idx_q == BYTE_HI_OVR) ? BYTE_HI_POL : idx_q + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus output

   // one byte of the result: low byte, or high byte with a flag in bit 7
   function automatic logic [7:0] pick_byte(
      input logic             low,
      input logic             range_sel,
      input logic [MAG_W-1:0] mag,
      input logic             pos,
      input logic             ovr
   );
      logic [7:0] b;
      if (low) begin
         b = mag[7:0];
      end else begin
         b = {(range_sel ? ovr : pos), mag[MAG_W-1:8]};
      end
      return b;
   endfunction

   // the bus is steered every cycle; the enable alone gates the pins
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_bus_o <= 8'h00;
      end else if (free_run_select_i) begin
         result_bus_o <= pick_byte(idx_q == BYTE_LO, idx_q == BYTE_HI_OVR,
                                   mag_q, pos_q, ovr_q);
      end else begin
         result_bus_o <= pick_byte(byte_low_sel_i, sign_or_range_select_i,
                                   mag_q, pos_q, ovr_q);
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_bus_oe_o <= 1'b0;
      end else begin
         result_bus_oe_o <= selected & ~rd_n_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [CNT_W-1:0] busy_len_q;
   logic [CNT_W-1:0] integ_len_q;

   // tick counts of the busy and integrate phases, for the checks only
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_len_q  <= '0;
         integ_len_q <= '0;
      end else begin
         busy_len_q  <= !busy_o ? '0 : busy_len_q + CNT_W'(tick);
         integ_len_q <= !integrate_o ? '0 : integ_len_q + CNT_W'(tick);
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_busy_fall;
      $fell(busy_o);
   endsequence

   sequence s_demand_start;
      !free_run_select_i && (state_q == ADCS_IDLE) && wr_fall;
   endsequence

   a_busy_width : assert property (s_busy_fall |-> busy_len_q == BUSY_LEN)
      else $error("busy high time is not 836 internal cycles");

   a_integ_width : assert property ($fell(integrate_o) |-> integ_len_q == INTEG_LEN)
      else $error("integration is not 256 internal cycles");

   a_busy_follows : assert property ($fell(integrate_o) |-> $rose(busy_o))
      else $error("busy did not rise as integration ended");

   a_demand_go : assert property (s_demand_start |-> ##[1:5] (state_q == ADCS_RUN && cnt_q == 11'h000))
      else $error("selected write strobe did not start a conversion");

   a_fall_point : assert property (s_busy_fall |-> cnt_q == BUSY_FALL && data_valid_o)
      else $error("busy fell at the wrong count or without valid data");

   a_ignore_early : assert property ((state_q == ADCS_RUN) && (cnt_q < IGNORE_LEN) && !req_q
      |=> !req_q)
      else $error("write strobe taken inside the lockout");

   a_pending_run : assert property (conv_end && req_q |=> state_q == ADCS_RUN && cnt_q == 11'h000)
      else $error("pending request did not start the next conversion");

   a_wrap_len : assert property (conv_end |-> $past(cnt_q, 4) == CONV_LAST - 11'h001)
      else $error("conversion did not last 1280 internal cycles");

   a_bus_drive : assert property (result_bus_oe_o |-> $past(selected && !rd_n_i))
      else $error("result bus driven without a selected read");

   a_byte_reset : assert property (win_expire |=> idx_q == BYTE_HI_POL)
      else $error("byte counter not restarted after the read window");

   a_no_repeat : assert property (!wr_prev_q && !wr_n_i |-> !wr_fall)
      else $error("held write level counted as a strobe");
endmodule
`default_nettype wire

// ==== tb_adcs_top.sv ====
// self-checking bench for the converter sequencer and result port
`default_nettype none
module tb_adcs_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adcs_pkg::*;
   logic             sys_clk_i = 1'b0;
   logic             resetn_i = 1'b0;
   logic             free_run_select_i = 1'b0;
   logic [MAG_W-1:0] mag_i = 15'h0000;
   logic             positive_i = 1'b0;
   logic             overrange_i = 1'b0;
   logic             chip_sel, chip_en_n, wr_n, rd_n, low_sel, range_sel;
   logic             busy_o, integrate_o, data_valid_o, result_bus_oe_o;
   logic [7:0]       result_bus_o;
   int               err_count = 0;
   int               n_tests = 0;
   int               cyc = 0;

   ////////////////////////////////////////////////////////////////////////////
   adcs_top u_adcs_top (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .free_run_select_i(free_run_select_i),
      .chip_sel_i(chip_sel), .chip_en_n_i(chip_en_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
      .byte_low_sel_i(low_sel), .sign_or_range_select_i(range_sel), .mag_i(mag_i),
      .positive_i(positive_i), .overrange_i(overrange_i), .busy_o(busy_o),
      .integrate_o(integrate_o), .data_valid_o(data_valid_o), .result_bus_o(result_bus_o),
      .result_bus_oe_o(result_bus_oe_o));
   adcs_host_model u_adcs_host_model (
      .sys_clk_i(sys_clk_i), .result_bus_i(result_bus_o), .result_bus_oe_i(result_bus_oe_o),
      .chip_sel_o(chip_sel), .chip_en_n_o(chip_en_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
      .byte_low_sel_o(low_sel), .sign_or_range_select_o(range_sel));

   ////////////////////////////////////////////////////////////////////////////
   // 50 MHz clock; the cycle ceiling sits well above the ~38k cycles the run needs
   always #10 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 32'h0001_5f90) begin
         err_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // bounded wait on busy (sel 0) or integrate (sel 1), sampled at falling edges
   task automatic wait_for(input int sel, input logic lvl, input int lim);
      int t;
      t = 0;
      while (((sel == 0) ? busy_o : integrate_o) !== lvl && t < lim) begin
         @(negedge sys_clk_i);
         t++;
      end
      check("phase level", 16'(lvl), 16'((sel == 0) ? busy_o : integrate_o));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one demand conversion, timed from the write edge
   task automatic demand_timing();
      int c0, c1, c2, c3;
      mag_i = 15'h5a3c;
      positive_i = 1'b1;
      c0 = cyc;
      u_adcs_host_model.strobe_write(1'b0);
      wait_for(1, 1'b1, 2000);
      c1 = cyc;
      wait_for(1, 1'b0, 1200);
      c2 = cyc;
      check("integrate length", 16'h0400, 16'(c2 - c1));
      check("busy at integrate end", 16'h0001, 16'(busy_o));
      wait_for(0, 1'b0, 3500);
      c3 = cyc;
      check("busy high length", 16'h0d10, 16'(c3 - c2));
      check("start to busy fall", 16'h0001, 16'(c3 - c0 >= 32'h0000_120c && c3 - c0 <= 32'h0000_1214));
      check("valid at busy fall", 16'h0001, 16'(data_valid_o));
   endtask

   // all four byte selections, then unselected reads leave the bus released
   task automatic demand_reads();
      logic [7:0] d, e;
      logic       oe;
      mag_i = 15'h0111;  // analog side moves on; the latched result must not
      positive_i = 1'b0;
      overrange_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_adcs_host_model.read_byte(i[0], i[1], d, oe);
         e = i[0] ? 8'h3c : {~i[1], 7'h5a};
         check("read enable", 16'h0001, 16'(oe));
         check("demand byte", 16'(e), 16'(d));
      end
      check("released after read", 16'h0000, 16'(result_bus_oe_o));
      u_adcs_host_model.set_sel(1'b0, 1'b0);
      u_adcs_host_model.read_byte(1'b1, 1'b0, d, oe);
      check("chip select off", 16'h0000, 16'(oe));
      u_adcs_host_model.set_sel(1'b1, 1'b1);
      u_adcs_host_model.read_byte(1'b1, 1'b0, d, oe);
      check("chip enable off", 16'h0000, 16'(oe));
      u_adcs_host_model.set_sel(1'b1, 1'b0);
   endtask

   // a held-low write late in the running conversion is kept pending and gives
   // exactly one more conversion; a strobe inside the next lockout is dropped
   task automatic demand_refused();
      logic [7:0] d;
      logic       oe;
      mag_i = 15'h7e81;
      u_adcs_host_model.strobe_write(1'b1);
      wait_for(0, 1'b1, 2000);
      u_adcs_host_model.release_write();
      u_adcs_host_model.strobe_write(1'b0);
      wait_for(0, 1'b0, 3400);
      u_adcs_host_model.read_byte(1'b1, 1'b0, d, oe);
      check("new low byte", 16'h0081, 16'(d));
      repeat (2000) @(negedge sys_clk_i);
      check("no extra conversion", 16'h0000, 16'(busy_o));
   endtask

   // a strobe after the lockout waits for the current conversion to end
   task automatic demand_pending();
      int c1, c2;
      u_adcs_host_model.strobe_write(1'b0);
      wait_for(0, 1'b1, 1400);
      wait_for(0, 1'b0, 3400);
      c1 = cyc;
      u_adcs_host_model.strobe_write(1'b0);
      wait_for(0, 1'b1, 2000);
      c2 = cyc;
      check("fall to next rise", 16'h06f0, 16'(c2 - c1));
      check("valid gone at rise", 16'h0000, 16'(data_valid_o));
      wait_for(0, 1'b0, 3400);
   endtask

   // free run: fixed byte order whatever the selects say, then window expiry
   task automatic free_run_seq();
      logic [7:0] d;
      logic [7:0] seq [3];
      logic       oe;
      int         c1, c2;
      seq = '{8'h2b, 8'hcd, 8'hab};
      mag_i = 15'h2bcd;
      free_run_select_i = 1'b1;
      wait_for(0, 1'b1, 6000);
      wait_for(0, 1'b0, 3400);
      // three reads back to back stay far inside the read window
      for (int i = 0; i < 3; i++) begin
         u_adcs_host_model.read_byte(1'b1, 1'b1, d, oe);
         check("free-run byte", 16'(seq[i]), 16'(d));
      end
      wait_for(0, 1'b1, 2000);
      c1 = cyc;
      wait_for(0, 1'b0, 3400);
      wait_for(0, 1'b1, 2000);
      c2 = cyc;
      check("conversion period", 16'h1400, 16'(c2 - c1));
      wait_for(0, 1'b0, 3400);
      u_adcs_host_model.read_byte(1'b0, 1'b0, d, oe);
      repeat (1800) @(negedge sys_clk_i);
      u_adcs_host_model.read_byte(1'b0, 1'b0, d, oe);
      check("first byte after window", 16'h002b, 16'(d));
      free_run_select_i = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // reset for ten cycles, then the scenarios in turn
   initial begin
      repeat (10) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      @(negedge sys_clk_i);
      check("idle after reset", 16'h0000, 16'({busy_o, integrate_o, data_valid_o, result_bus_oe_o}));
      demand_timing();
      demand_reads();
      demand_refused();
      demand_pending();
      free_run_seq();
      summarize();
   end
endmodule
`default_nettype wire
